// ---- src/line_alarm_pkg.sv ----
// constants, field layouts and types of the line alarm and pattern select block
package line_alarm_pkg;

  // ----------------------------------------------------------------
  // register map: printed index, byte address is four times it
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW          = 12;
  localparam logic [11:0] IDX_RX_CFG_ONE  = 12'h008;
  localparam logic [11:0] IDX_MAINT_ZERO  = 12'h00a;
  localparam logic [11:0] IDX_STATUS_ZERO = 12'h014;
  localparam logic [11:0] IDX_GLOBAL_ZERO = 12'h040;
  localparam logic [11:0] ADDR_RX_CFG_ONE  = {IDX_RX_CFG_ONE[9:0], 2'b00};
  localparam logic [11:0] ADDR_MAINT_ZERO  = {IDX_MAINT_ZERO[9:0], 2'b00};
  localparam logic [11:0] ADDR_STATUS_ZERO = {IDX_STATUS_ZERO[9:0], 2'b00};
  localparam logic [11:0] ADDR_GLOBAL_ZERO = {IDX_GLOBAL_ZERO[9:0], 2'b00};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_LEVEL_CODE = 5'h15;
  localparam logic [7:0] RST_MAINT_ZERO = 8'h00;
  localparam logic [7:0] RST_GLOBAL     = 8'h04;

  // ----------------------------------------------------------------
  // absence detection counts, in symbol periods
  // ----------------------------------------------------------------
  localparam logic [11:0] DECL_T1_CRIT0   = 12'h0af;
  localparam logic [11:0] DECL_T1_CRIT1   = 12'h608;
  localparam logic [11:0] DECL_E1_CRIT0   = 12'h020;
  localparam logic [11:0] DECL_E1_CRIT1   = 12'h800;
  localparam logic [11:0] CLR_WIN_T1      = 12'h080;
  localparam logic [11:0] CLR_WIN_E1      = 12'h020;
  localparam logic [11:0] CLR_ZRUN_T1     = 12'h064;
  localparam logic [11:0] CLR_ZRUN_E1     = 12'h010;
  localparam int unsigned DENSITY_SHIFT   = 3;

  // ----------------------------------------------------------------
  // level thresholds: mVpp in short haul, dB below nominal in long haul
  // ----------------------------------------------------------------
  localparam logic [10:0] SH_DECLARE_MV  = 11'h320;
  localparam logic [10:0] SH_HYST_MV     = 11'h0c8;
  localparam logic [10:0] LH_BASE_DB     = 11'h004;
  localparam logic [10:0] LH_FLOOR_DB    = 11'h030;
  localparam logic [10:0] LH_HYST_DB     = 11'h004;
  localparam logic [4:0]  LH_MAX_CODE    = 5'h15;

  // ----------------------------------------------------------------
  // all-ones alarm blocks
  // ----------------------------------------------------------------
  localparam logic [13:0] AIS_BLK_E1  = 14'h0200;
  localparam logic [13:0] AIS_BLK_T1  = 14'h2000;
  localparam logic [3:0]  AIS_ZTH_E1  = 4'h3;
  localparam logic [3:0]  AIS_ZTH_T1  = 4'h9;

  localparam logic [19:0] PRBS_SEED   = 20'hf_ffff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PAT_NORMAL = 2'b00,
    PAT_ONES   = 2'b01,
    PAT_PRBS   = 2'b10,
    PAT_LOOP   = 2'b11
  } pattern_type;

  typedef enum logic [2:0] {
    SIG_PRESENT  = 3'b001,
    SIG_ABSENT   = 3'b010,
    SIG_CLEARING = 3'b100
  } absence_state_type;

  typedef struct packed {
    logic [1:0]  unused;
    logic        pattern_clk_sel;
    pattern_type tx_pattern_sel;
    logic        tx_alarm_fill_en;
    logic        rx_alarm_fill_en;
    logic        criterion_select;
  } maint_type;

  typedef struct packed {
    logic [4:0] unused;
    logic       cdr_en;
    logic       long_haul;
    logic       rate_standard_sel;
  } global_type;

  typedef struct packed {
    logic [5:0] unused;
    logic       alarm_fill_seen;
    logic       signal_absent;
  } status_type;

endpackage

// ---- src/line_alarm_and_pattern_select.sv ----
// receive absence and all-ones alarm detection, alarm fill and transmit pattern select
`timescale 1ns/10ps
module line_alarm_and_pattern_select
  import line_alarm_pkg::*;
(
  input  wire logic              CORE_CLK_I,           // 100 MHz core clock
  input  wire logic              RST_B_I,              // async reset, active low
  input  wire logic              CE_I,                 // clock enable, freezes all state
  input  wire logic              PSEL_I,               // apb select
  input  wire logic              PENABLE_I,            // apb enable
  input  wire logic              PWRITE_I,             // apb write
  input  wire logic [APB_AW-1:0] PADDR_I,              // apb byte address
  input  wire logic [31:0]       PWDATA_I,             // apb write data
  output logic      [31:0]       PRDATA_O,             // apb read data
  output logic                   PREADY_O,             // apb ready
  output logic                   PSLVERR_O,            // apb error on unmapped address
  input  wire logic              RX_SYM_STB_I,         // one pulse per received symbol period
  input  wire logic              RX_MARK_I,            // received symbol is a mark
  input  wire logic              LEVEL_BELOW_DECLARE_I, // comparator: level below declare threshold
  input  wire logic              LEVEL_ABOVE_CLEAR_I,  // comparator: level above clear threshold
  input  wire logic              RX_RECOVERED_CLK_I,   // recovered receive clock level
  input  wire logic              RX_POS_I,             // recovered positive rail
  input  wire logic              RX_NEG_I,             // recovered negative rail
  input  wire logic              MASTER_CLK_I,         // master clock level
  input  wire logic              TX_CLOCK_IN_I,        // transmit clock level
  input  wire logic              TX_SYS_POS_I,         // system transmit positive rail
  input  wire logic              TX_SYS_NEG_I,         // system transmit negative rail
  output logic                   SIGNAL_ABSENT_OUT_O,  // signal absence indication
  output logic                   ABSENCE_EVENT_O,      // one-cycle pulse on declare
  output logic      [10:0]       DECLARE_THRESH_O,     // declare threshold to comparator
  output logic      [10:0]       CLEAR_THRESH_O,       // clear threshold to comparator
  output logic                   THRESH_IN_DB_O,       // thresholds in dB (1) or mVpp (0)
  output logic                   RX_CLOCK_OUT_O,       // receive clock to system
  output logic                   RX_DATA_POS_O,        // receive positive rail to system
  output logic                   RX_DATA_NEG_O,        // receive negative rail to system
  output logic                   LINE_TX_TIP_O,        // transmit line tip drive
  output logic                   LINE_TX_RING_O,       // transmit line ring drive
  output logic                   TX_REF_CLK_O          // reference clock of transmit stream
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [4:0]  absence_level_code;
  maint_type   maint;
  global_type  glob;
  status_type  status;

  logic        rate_t1;
  logic        crit;
  logic        setup_phase;
  logic        access_done;
  logic        addr_hit;

  assign rate_t1     = glob.rate_standard_sel;
  assign crit        = maint.criterion_select;
  assign setup_phase = PSEL_I & ~PENABLE_I & ~PREADY_O;
  assign access_done = PSEL_I & PENABLE_I & PREADY_O;
  assign addr_hit    = (PADDR_I == ADDR_RX_CFG_ONE) | (PADDR_I == ADDR_MAINT_ZERO) |
                       (PADDR_I == ADDR_STATUS_ZERO) | (PADDR_I == ADDR_GLOBAL_ZERO);

  // ----------------------------------------------------------------
  // apb slave: one registered answer per setup, no further waits
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else if (CE_I) begin
      if (setup_phase) begin
        PREADY_O  <= 1'b1;
        PSLVERR_O <= ~addr_hit;
        PRDATA_O  <= 32'h0000_0000;
        if (!PWRITE_I) begin
          case (PADDR_I)
            ADDR_RX_CFG_ONE:  PRDATA_O <= {27'h000_0000, absence_level_code};
            ADDR_MAINT_ZERO:  PRDATA_O <= {24'h00_0000, maint};
            ADDR_STATUS_ZERO: PRDATA_O <= {24'h00_0000, status};
            ADDR_GLOBAL_ZERO: PRDATA_O <= {24'h00_0000, glob};
            default:          PRDATA_O <= 32'h0000_0000;
          endcase
        end
      end else if (access_done) begin
        PREADY_O  <= 1'b0;
        PSLVERR_O <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      absence_level_code <= RST_LEVEL_CODE;
      maint              <= RST_MAINT_ZERO;
      glob               <= RST_GLOBAL;
    end else if (CE_I && access_done && PWRITE_I) begin
      case (PADDR_I)
        ADDR_RX_CFG_ONE:  absence_level_code <= PWDATA_I[4:0];
        ADDR_MAINT_ZERO:  maint <= {2'b00, PWDATA_I[5:0]};
        ADDR_GLOBAL_ZERO: glob  <= {5'h00, PWDATA_I[2:0]};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // level thresholds handed to the analog comparators
  // ----------------------------------------------------------------
  logic [10:0] lh_declare_db;

  always_comb begin
    if (absence_level_code > LH_MAX_CODE) begin
      lh_declare_db = LH_FLOOR_DB;
    end else begin
      lh_declare_db = LH_BASE_DB + {5'h00, absence_level_code, 1'b0};
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DECLARE_THRESH_O <= SH_DECLARE_MV;
      CLEAR_THRESH_O   <= SH_DECLARE_MV + SH_HYST_MV;
      THRESH_IN_DB_O   <= 1'b0;
    end else if (CE_I) begin
      THRESH_IN_DB_O <= glob.long_haul;
      if (glob.long_haul) begin
        DECLARE_THRESH_O <= lh_declare_db;
        CLEAR_THRESH_O   <= lh_declare_db - LH_HYST_DB; // 4 dB less loss
      end else begin
        DECLARE_THRESH_O <= SH_DECLARE_MV;
        CLEAR_THRESH_O   <= SH_DECLARE_MV + SH_HYST_MV;
      end
    end
  end

  // ----------------------------------------------------------------
  // signal absence declare and clear
  // ----------------------------------------------------------------
  // detection always watches the comparators, whatever loopback is set
  absence_state_type abs_state;
  logic [11:0] declare_n;
  logic [11:0] clear_m;
  logic [11:0] zrun_limit;
  logic [11:0] decl_cnt;
  logic [11:0] win_cnt;
  logic [11:0] mark_cnt;
  logic [11:0] zrun;
  logic [11:0] next_mark_cnt;
  logic [11:0] next_zrun;

  always_comb begin
    if (rate_t1) begin
      declare_n  = crit ? DECL_T1_CRIT1 : DECL_T1_CRIT0;
      clear_m    = CLR_WIN_T1;
      zrun_limit = CLR_ZRUN_T1;
    end else begin
      declare_n  = crit ? DECL_E1_CRIT1 : DECL_E1_CRIT0;
      clear_m    = CLR_WIN_E1;
      zrun_limit = CLR_ZRUN_E1;
    end
    next_mark_cnt = mark_cnt + {11'h000, RX_MARK_I};
    next_zrun     = RX_MARK_I ? 12'h000 : zrun + 12'h001;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      abs_state           <= SIG_PRESENT;
      decl_cnt            <= 12'h000;
      win_cnt             <= 12'h000;
      mark_cnt            <= 12'h000;
      zrun                <= 12'h000;
      SIGNAL_ABSENT_OUT_O <= 1'b0;
      ABSENCE_EVENT_O     <= 1'b0;
    end else if (CE_I) begin
      ABSENCE_EVENT_O <= 1'b0;
      if (RX_SYM_STB_I) begin
        case (abs_state)
          SIG_PRESENT: begin
            if (!LEVEL_BELOW_DECLARE_I) begin
              decl_cnt <= 12'h000;
            end else if (decl_cnt >= declare_n - 12'h001) begin
              abs_state           <= SIG_ABSENT;
              decl_cnt            <= 12'h000;
              SIGNAL_ABSENT_OUT_O <= 1'b1;
              ABSENCE_EVENT_O     <= 1'b1;
            end else begin
              decl_cnt <= decl_cnt + 12'h001;
            end
          end
          SIG_ABSENT: begin
            // the clear window opens only on a received pulse
            if (RX_MARK_I && LEVEL_ABOVE_CLEAR_I) begin
              abs_state <= SIG_CLEARING;
              win_cnt   <= 12'h001;
              mark_cnt  <= 12'h001;
              zrun      <= 12'h000;
            end
          end
          SIG_CLEARING: begin
            if (!LEVEL_ABOVE_CLEAR_I || next_zrun >= zrun_limit) begin
              abs_state <= SIG_ABSENT;
            end else if (win_cnt == clear_m - 12'h001) begin
              // density checked over the whole window, not per byte
              if (next_mark_cnt >= (clear_m >> DENSITY_SHIFT)) begin
                abs_state           <= SIG_PRESENT;
                SIGNAL_ABSENT_OUT_O <= 1'b0;
                decl_cnt            <= 12'h000;
              end else begin
                abs_state <= SIG_ABSENT;
              end
            end else begin
              win_cnt  <= win_cnt + 12'h001;
              mark_cnt <= next_mark_cnt;
              zrun     <= next_zrun;
            end
          end
          default: begin
            abs_state <= SIG_PRESENT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // all-ones alarm detection in fixed blocks
  // ----------------------------------------------------------------
  logic [13:0] blk_cnt;
  logic [13:0] blk_len;
  logic [3:0]  zeros;
  logic [3:0]  next_zeros;
  logic [3:0]  zero_th;
  logic        prev_few;
  logic        few;
  logic        alarm_fill_seen;

  always_comb begin
    blk_len    = rate_t1 ? AIS_BLK_T1 : AIS_BLK_E1;
    zero_th    = rate_t1 ? AIS_ZTH_T1 : AIS_ZTH_E1;
    next_zeros = (RX_MARK_I || zeros == 4'hf) ? zeros : zeros + 4'h1; // saturates
    few        = next_zeros < zero_th;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      blk_cnt         <= 14'h0000;
      zeros           <= 4'h0;
      prev_few        <= 1'b0;
      alarm_fill_seen <= 1'b0;
    end else if (CE_I) begin
      if (!glob.cdr_en) begin
        blk_cnt         <= 14'h0000;
        zeros           <= 4'h0;
        prev_few        <= 1'b0;
        alarm_fill_seen <= 1'b0;
      end else if (RX_SYM_STB_I) begin
        if (blk_cnt == blk_len - 14'h0001) begin
          blk_cnt  <= 14'h0000;
          zeros    <= 4'h0;
          prev_few <= few;
          if (rate_t1) begin
            alarm_fill_seen <= few;
          end else if (!crit) begin
            if (few && prev_few) begin
              alarm_fill_seen <= 1'b1;
            end else if (!few && !prev_few) begin
              alarm_fill_seen <= 1'b0;
            end
          end else begin
            if (!few) begin
              alarm_fill_seen <= 1'b0;
            end else if (prev_few) begin
              alarm_fill_seen <= 1'b1;
            end
          end
        end else begin
          blk_cnt <= blk_cnt + 14'h0001;
          zeros   <= next_zeros;
        end
      end
    end
  end

  assign status = {6'h00, alarm_fill_seen, SIGNAL_ABSENT_OUT_O};

  // ----------------------------------------------------------------
  // receive system side with alarm fill
  // ----------------------------------------------------------------
  logic mclk_q;
  logic mclk_rise;
  logic rx_fill_pol;
  logic rx_fill;

  assign mclk_rise = MASTER_CLK_I & ~mclk_q;
  assign rx_fill   = SIGNAL_ABSENT_OUT_O & maint.rx_alarm_fill_en;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mclk_q         <= 1'b0;
      rx_fill_pol    <= 1'b0;
      RX_CLOCK_OUT_O <= 1'b0;
      RX_DATA_POS_O  <= 1'b0;
      RX_DATA_NEG_O  <= 1'b0;
    end else if (CE_I) begin
      mclk_q <= MASTER_CLK_I;
      if (mclk_rise) begin
        rx_fill_pol <= ~rx_fill_pol;
      end
      if (rx_fill) begin
        // all ones as alternating marks, paced by the master clock
        RX_CLOCK_OUT_O <= MASTER_CLK_I;
        RX_DATA_POS_O  <= rx_fill_pol;
        RX_DATA_NEG_O  <= ~rx_fill_pol;
      end else begin
        RX_CLOCK_OUT_O <= RX_RECOVERED_CLK_I;
        RX_DATA_POS_O  <= RX_POS_I;
        RX_DATA_NEG_O  <= RX_NEG_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit pattern select
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        ref_q;
  logic        ref_rise;
  logic        tx_pol;
  logic [19:0] prbs;
  logic [19:0] next_prbs;
  logic        prbs_bit;

  always_comb begin
    if (maint.tx_alarm_fill_en) begin
      ref_clk = MASTER_CLK_I;
    end else begin
      ref_clk = maint.pattern_clk_sel ? MASTER_CLK_I : TX_CLOCK_IN_I;
    end
    ref_rise = ref_clk & ~ref_q;
    if (rate_t1) begin
      prbs_bit  = prbs[19];
      next_prbs = {prbs[18:0], prbs[19] ^ prbs[16]};
    end else begin
      prbs_bit  = prbs[14];
      next_prbs = {5'h00, prbs[13:0], prbs[14] ^ prbs[13]};
    end
    // a rate change can leave the short register empty; reseed then
    if (next_prbs == 20'h0_0000) begin
      next_prbs = PRBS_SEED;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ref_q          <= 1'b0;
      tx_pol         <= 1'b0;
      prbs           <= PRBS_SEED;
      LINE_TX_TIP_O  <= 1'b0;
      LINE_TX_RING_O <= 1'b0;
      TX_REF_CLK_O   <= 1'b0;
    end else if (CE_I) begin
      ref_q        <= ref_clk;
      TX_REF_CLK_O <= ref_clk;
      if (maint.tx_alarm_fill_en || maint.tx_pattern_sel == PAT_ONES) begin
        if (ref_rise) begin
          tx_pol         <= ~tx_pol;
          LINE_TX_TIP_O  <= tx_pol;
          LINE_TX_RING_O <= ~tx_pol;
        end
      end else if (maint.tx_pattern_sel == PAT_PRBS) begin
        if (ref_rise) begin
          prbs <= next_prbs;
          if (prbs_bit) begin
            tx_pol <= ~tx_pol;
          end
          LINE_TX_TIP_O  <= prbs_bit & tx_pol;
          LINE_TX_RING_O <= prbs_bit & ~tx_pol;
        end
      end else if (maint.tx_pattern_sel == PAT_NORMAL && maint.pattern_clk_sel) begin
        LINE_TX_TIP_O  <= 1'b0;
        LINE_TX_RING_O <= 1'b0;
      end else begin
        // loop codes are not generated here; system data passes
        LINE_TX_TIP_O  <= TX_SYS_POS_I;
        LINE_TX_RING_O <= TX_SYS_NEG_I;
      end
    end
  end

endmodule

// ---- verification/line_alarm_far_side.sv ----
// far-side line model: symbol strobes, received rails and free-running clock levels
`timescale 1ns/10ps
module line_alarm_far_side (
  input  wire logic       clk_i,   // core clock
  input  wire logic       rst_b_i, // reset, active low
  input  wire logic       mark_i,  // symbol is a mark
  output logic            stb_o,   // symbol strobe
  output logic            pos_o,   // positive rail
  output logic            neg_o,   // negative rail
  output logic      [2:0] clk_o    // recovered, master, transmit clock levels
);
  logic [3:0] cnt;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  // marks alternate polarity, a space leaves both rails low
  assign stb_o = cnt[1:0] == 2'h3;
  assign pos_o = mark_i & cnt[2];
  assign neg_o = mark_i & ~cnt[2];
  assign clk_o = {cnt[2], cnt[0], cnt[1]};
endmodule

// ---- verification/line_alarm_chk.sv ----
// concurrent checks on the line alarm block ports
`timescale 1ns/10ps
module line_alarm_chk (
  input wire logic        CORE_CLK_I,          // clock
  input wire logic        RST_B_I,             // reset
  input wire logic        CE_I,                // enable
  input wire logic        PSEL_I,              // select
  input wire logic        PENABLE_I,           // access phase
  input wire logic        PREADY_O,            // ready
  input wire logic        PSLVERR_O,           // error
  input wire logic        SIGNAL_ABSENT_OUT_O, // absence
  input wire logic        ABSENCE_EVENT_O,     // declare pulse
  input wire logic        THRESH_IN_DB_O,      // db units
  input wire logic [10:0] DECLARE_THRESH_O,    // declare level
  input wire logic [10:0] CLEAR_THRESH_O,      // clear level
  input wire logic        RX_POS_I,            // rail in
  input wire logic        RX_DATA_POS_O        // rail out
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held");
  a_ready_setup: assert property (CE_I && PSEL_I && !PENABLE_I && !PREADY_O |=> PREADY_O) else $error("no ready");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  a_event_pulse: assert property (ABSENCE_EVENT_O |=> !ABSENCE_EVENT_O) else $error("event held");
  a_event_rise: assert property ($rose(SIGNAL_ABSENT_OUT_O) |-> ABSENCE_EVENT_O) else $error("no event");
  a_short_level: assert property (!THRESH_IN_DB_O |-> DECLARE_THRESH_O == 11'h320 && CLEAR_THRESH_O == 11'h3e8)
    else $error("short haul level");
  a_long_hyst: assert property (THRESH_IN_DB_O |-> DECLARE_THRESH_O == CLEAR_THRESH_O + 11'h004)
    else $error("long haul hysteresis");
  a_long_step: assert property (THRESH_IN_DB_O |-> DECLARE_THRESH_O inside {[4:48]} && !DECLARE_THRESH_O[0])
    else $error("long haul step");
  a_rx_pass: assert property ((CE_I && !SIGNAL_ABSENT_OUT_O) [*2] |-> RX_DATA_POS_O == $past(RX_POS_I))
    else $error("rail not passed");
  c_declare: cover property ($rose(SIGNAL_ABSENT_OUT_O));
  c_clear: cover property ($fell(SIGNAL_ABSENT_OUT_O));
  c_long: cover property (THRESH_IN_DB_O);
endmodule
bind line_alarm_and_pattern_select line_alarm_chk line_alarm_chk_inst (.CORE_CLK_I, .RST_B_I, .CE_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .PSLVERR_O, .SIGNAL_ABSENT_OUT_O, .ABSENCE_EVENT_O, .THRESH_IN_DB_O, .DECLARE_THRESH_O,
  .CLEAR_THRESH_O, .RX_POS_I, .RX_DATA_POS_O);

// ---- verification/line_alarm_and_pattern_select_bench.sv ----
// self-checking bench: registers, absence counts, level codes, all-ones alarm
`timescale 1ns/10ps
module line_alarm_and_pattern_select_bench;
  import line_alarm_pkg::*;
  logic        CORE_CLK_I = 1'b0, RST_B_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0, e;
  logic        LEVEL_BELOW_DECLARE_I = 1'b0, LEVEL_ABOVE_CLEAR_I = 1'b0, RX_MARK_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0000_0000, PRDATA_O, q;
  logic [10:0] DECLARE_THRESH_O, CLEAR_THRESH_O;
  logic [2:0]  lclk, p;
  logic        PREADY_O, PSLVERR_O, RX_SYM_STB_I, RX_POS_I, RX_NEG_I, SIGNAL_ABSENT_OUT_O, ABSENCE_EVENT_O;
  logic        THRESH_IN_DB_O, RX_CLOCK_OUT_O, RX_DATA_POS_O, RX_DATA_NEG_O, LINE_TX_TIP_O, LINE_TX_RING_O, TX_REF_CLK_O;
  logic [11:0] ra[4] = '{ADDR_RX_CFG_ONE, ADDR_MAINT_ZERO, ADDR_STATUS_ZERO, ADDR_GLOBAL_ZERO};
  int          rv[4] = '{21, 0, 0, 4}, decl[4] = '{32, 2048, 175, 1544}, clr[4] = '{32, 32, 128, 128};
  int          code[4] = '{0, 1, 21, 31}, agl[3] = '{0, 4, 4}, aex[3] = '{0, 2, 0};
  int          tm[5] = '{0, 32, 8, 4, 16}, rs[5] = '{2, 1, 2, 1, 2};
  logic        amk[3] = '{1'b1, 1'b1, 1'b0};
  int          err_count = 0, cmp_count = 0, n;
  always #5 CORE_CLK_I = ~CORE_CLK_I;
  line_alarm_and_pattern_select line_alarm_and_pattern_select_inst (.CORE_CLK_I, .RST_B_I, .CE_I(1'b1), .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .RX_SYM_STB_I, .RX_MARK_I,
    .LEVEL_BELOW_DECLARE_I, .LEVEL_ABOVE_CLEAR_I, .RX_RECOVERED_CLK_I(lclk[0]), .RX_POS_I, .RX_NEG_I,
    .MASTER_CLK_I(lclk[1]), .TX_CLOCK_IN_I(lclk[2]), .TX_SYS_POS_I(lclk[0]), .TX_SYS_NEG_I(lclk[2]), .SIGNAL_ABSENT_OUT_O,
    .ABSENCE_EVENT_O, .DECLARE_THRESH_O, .CLEAR_THRESH_O, .THRESH_IN_DB_O, .RX_CLOCK_OUT_O, .RX_DATA_POS_O,
    .RX_DATA_NEG_O, .LINE_TX_TIP_O, .LINE_TX_RING_O, .TX_REF_CLK_O);
  line_alarm_far_side line_alarm_far_side_inst (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .mark_i(RX_MARK_I),
    .stb_o(RX_SYM_STB_I), .pos_o(RX_POS_I), .neg_o(RX_NEG_I), .clk_o(lclk));
  task automatic end_of_test;
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    PSEL_I <= 1'b1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
    @(posedge CORE_CLK_I);
    PENABLE_I <= 1'b1;
    i = 0;
    do begin
      @(posedge CORE_CLK_I);
      i++;
    end while (PREADY_O !== 1'b1 && i < 50);
    q = PRDATA_O;
    e = PSLVERR_O;
    chk("ready", 32'h0000_0001, {31'h0, PREADY_O});
    if (PREADY_O !== 1'b1) end_of_test();
    PSEL_I <= 1'b0; PENABLE_I <= 1'b0;
    @(posedge CORE_CLK_I);
  endtask
  // counts symbol strobes until the absence output reaches lvl
  task automatic watch(input logic lvl, input int m, input string s);
    n = 0;
    for (int i = 0; i < 20000 && SIGNAL_ABSENT_OUT_O !== lvl; i++) begin
      @(posedge CORE_CLK_I);
      if (RX_SYM_STB_I === 1'b1) n++;
    end
    chk(s, m, n);
    if (SIGNAL_ABSENT_OUT_O !== lvl) end_of_test();
  endtask
  initial begin
    repeat (8) @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    apb(1'b1, ADDR_STATUS_ZERO, 32'h0000_00ff);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", rv[i], q);
    end
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    apb(1'b1, ADDR_GLOBAL_ZERO, 32'h0000_0006);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_RX_CFG_ONE, code[i]);
      repeat (2) @(posedge CORE_CLK_I);
      chk("declare level", (code[i] > 21) ? 48 : 4 + 2 * code[i], {21'h0, DECLARE_THRESH_O});
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_GLOBAL_ZERO, 32'h0000_0004 | 32'(k >> 1));
      apb(1'b1, ADDR_MAINT_ZERO, 32'h0000_0002 | 32'(k & 1));
      LEVEL_BELOW_DECLARE_I <= 1'b1; LEVEL_ABOVE_CLEAR_I <= 1'b0; RX_MARK_I <= 1'b0;
      watch(1'b1, decl[k], "declare count");
      chk("absence event", 32'h0000_0001, {31'h0, ABSENCE_EVENT_O});
      apb(1'b0, ADDR_STATUS_ZERO, 32'h0000_0000);
      chk("status absent", 32'h0000_0001, q);
      p = lclk;
      @(posedge CORE_CLK_I);
      chk("rx fill clock", {31'h0, p[1]}, {31'h0, RX_CLOCK_OUT_O});
      chk("rx fill rails", 32'h0000_0001, {31'h0, RX_DATA_POS_O ^ RX_DATA_NEG_O});
      LEVEL_BELOW_DECLARE_I <= 1'b0; LEVEL_ABOVE_CLEAR_I <= 1'b1; RX_MARK_I <= 1'b1;
      watch(1'b0, clr[k], "clear count");
    end
    for (int k = 0; k < 3; k++) begin
      RX_MARK_I <= amk[k];
      apb(1'b1, ADDR_GLOBAL_ZERO, agl[k]);
      apb(1'b1, ADDR_MAINT_ZERO, 32'h0000_0000);
      repeat (6400) @(posedge CORE_CLK_I);
      apb(1'b0, ADDR_STATUS_ZERO, 32'h0000_0000);
      chk("alarm status", aex[k], q);
    end
    // normal, zeros, ones, tx fill, pseudo-random from an all-ones seed
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, ADDR_MAINT_ZERO, tm[k]);
      repeat (10) @(posedge CORE_CLK_I);
      p = lclk;
      @(posedge CORE_CLK_I);
      chk("tx ref clock", {31'h0, p[rs[k]]}, {31'h0, TX_REF_CLK_O});
      if (k < 2) begin
        chk("tx line", (k == 0) ? {p[0], p[2]} : 2'b00, {LINE_TX_TIP_O, LINE_TX_RING_O});
      end else begin
        chk("tx marks", 32'h0000_0001, {31'h0, LINE_TX_TIP_O ^ LINE_TX_RING_O});
      end
    end
    end_of_test();
  end
endmodule
